// >>> src/vpc_pkg.sv
/*
 Package for the first-stage PLL control register bank: register addresses,
 field positions, reset values and the carrier structs for bank requests and outputs.
 Assumes an 8-bit address and 8-bit data configuration port.
*/
`default_nettype none
package vpc_pkg;
	localparam int VPC_AW = 8;
	localparam int VPC_DW = 8;

	localparam logic [7:0] VPC_ADDR_FB_CASCADE = 8'h03;
	localparam logic [7:0] VPC_ADDR_LOOP_BYPASS = 8'h0A;
	localparam logic [7:0] VPC_ADDR_TUNE_PUMP = 8'h10;
	localparam logic [7:0] VPC_ADDR_OSC_OUT = 8'h11;
	localparam logic [7:0] VPC_ADDR_LOOP2_PUMP = 8'h12;

	localparam int VPC_BIT_FB_CASCADE = 0;
	localparam int VPC_BIT_LOOP_BYPASS = 0;
	localparam int VPC_BIT_TUNE_POL = 7;
	localparam int VPC_BIT_FORCE_MID = 6;
	localparam int VPC_PUMP_LSB = 0;
	localparam int VPC_PUMP_W = 5;
	localparam int VPC_BIT_OSC_PWR = 7;

	localparam logic VPC_RST_FB_CASCADE = 1'h0;
	localparam logic VPC_RST_LOOP_BYPASS = 1'h0;
	localparam logic VPC_RST_TUNE_POL = 1'h0;
	localparam logic VPC_RST_FORCE_MID = 1'h1;
	localparam logic [4:0] VPC_RST_PUMP = 5'h18;
	localparam logic VPC_RST_OSC_PWR = 1'h0;
	localparam logic [6:0] VPC_RST_OSC_REST = 7'h00;
	localparam logic [6:0] VPC_RST_LOOP2 = 7'h18;

	// Pump current step in microamps; current = step * (code + 1)
	localparam int VPC_PUMP_STEP_UA = 50;

	typedef struct packed {
		logic feedback_cascade_select;
		logic first_loop_bypass;
		logic tuning_polarity;
		logic force_mid_tuning;
		logic [4:0] first_loop_pump_current;
		logic osc_copy_output_power;
	} vpc_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vpc_req_t;
endpackage
`default_nettype wire

// >>> src/vpc_pump_dac.sv
/*
 Pump current computation: converts the pump code into a current in microamps.
 Assumes a static code from the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
module vpc_pump_dac (
	input wire logic clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic [4:0] code, // Pump current code
	output logic [10:0] current_ua // Pump current in microamps
);
	import vpc_pkg::*;
	logic [10:0] current_ua_reg;

	always_ff @(posedge clk) begin
		if (rst)
			current_ua_reg <= 11'h000;
		else
			current_ua_reg <= 11'(VPC_PUMP_STEP_UA * (int'(code) + 1)); // [R6]
	end
	assign current_ua = current_ua_reg;
endmodule
`default_nettype wire

// >>> src/vpc_regs.sv
/*
 First-stage PLL control register bank with its decoded control outputs.
 Assumes a synchronous single-cycle configuration port already in the clk
 domain (the serial front end lives elsewhere). A strobe is taken on the edge
 that sees it high; reads answer one cycle later, and a read in the cycle of a
 write to the same register returns the value from before the write.
 Bits 6:0 of osc_output_offset_ctrl and second_loop_pump_ctrl are only stored here (bit 7 of the latter is reserved);
 the logic that uses them sits outside this bank.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Bit 0 of feedback_cascade_ctrl clear uses main divider; set cascades main and secondary.
// [R2] Bit 0 of loop_bypass_ctrl set bypasses the first loop; resets to zero.
// [R3] Bit 7 of tuning_and_pump_ctrl picks tuning slope, clear positive; resets clear.
// [R4] Bit 6 of tuning_and_pump_ctrl resets to one and forces tuning voltage to mid.
// [R5] Host should clear the force bit after startup so the loop locks.
// [R6] Pump current equals unit step times code plus one.
// [R7] Pump code resets to 24, giving 1.25 mA.
// [R8] Bit 7 of osc_output_offset_ctrl powers the oscillator copy output; resets clear.
// [R9] Reserved bits read zero and ignore writes.
module vpc_regs #(
	parameter int ADDR_W = vpc_pkg::VPC_AW, // Configuration address width
	parameter int DATA_W = vpc_pkg::VPC_DW // Configuration data width
) (
	input wire logic clk, // Clock, 40 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire vpc_pkg::vpc_req_t req, // Register write/read request
	output logic [7:0] rdata, // Read data, registered
	output logic rvalid, // Read data valid pulse
	output vpc_pkg::vpc_ctrl_t ctrl, // Decoded control fields
	output logic feedback_cascade_select, // 1: main x secondary divider
	output logic first_loop_bypass, // 1: loop disabled and bypassed
	output logic tuning_polarity, // 1: negative tuning slope
	output logic force_mid_tuning, // 1: tuning voltage at mid-supply
	output logic osc_copy_output_power, // 1: copy output powered up
	output logic [10:0] first_loop_pump_ua // Pump current in microamps
);
	import vpc_pkg::*;

	logic fb_cascade_reg;
	logic loop_bypass_reg;
	logic tune_pol_reg;
	logic force_mid_reg;
	logic [4:0] pump_reg;
	logic osc_pwr_reg;
	// Other fields of osc_output_offset_ctrl and second_loop_pump_ctrl belong to logic outside this bank but
	// must still read back what was written.
	logic [6:0] osc_out_rest_reg;
	logic [6:0] loop2_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic [7:0] rd_next;
	// One decoded strobe per register keeps each field process to one test
	logic wr_fb_cascade;
	logic wr_loop_bypass;
	logic wr_tune_pump;
	logic wr_osc_out;
	logic wr_loop2_pump;
	// Read images with reserved positions tied low in one place [R9]
	logic [7:0] img_fb_cascade;
	logic [7:0] img_loop_bypass;
	logic [7:0] img_tune_pump;
	logic [7:0] img_osc_out;
	logic [7:0] img_loop2_pump;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// The field map is laid out for eight-bit registers only
	if (ADDR_W != 8) begin : g_addr_check
		$error("configuration address must be 8 bits wide");
	end
	if (DATA_W != 8) begin : g_data_check
		$error("configuration data must be 8 bits wide");
	end
	// Pump code must not overlap the polarity and force bits of tuning_and_pump_ctrl
	if (VPC_PUMP_LSB + VPC_PUMP_W > VPC_BIT_FORCE_MID) begin : g_pump_check
		$error("pump field overlaps the tuning control bits");
	end

	assign wr_fb_cascade = req.wr && hit(req.addr, VPC_ADDR_FB_CASCADE);
	assign wr_loop_bypass = req.wr && hit(req.addr, VPC_ADDR_LOOP_BYPASS);
	assign wr_tune_pump = req.wr && hit(req.addr, VPC_ADDR_TUNE_PUMP);
	assign wr_osc_out = req.wr && hit(req.addr, VPC_ADDR_OSC_OUT);
	assign wr_loop2_pump = req.wr && hit(req.addr, VPC_ADDR_LOOP2_PUMP);

	always_ff @(posedge clk) begin
		if (rst)
			fb_cascade_reg <= VPC_RST_FB_CASCADE;
		else if (wr_fb_cascade)
			fb_cascade_reg <= req.wdata[VPC_BIT_FB_CASCADE]; // [R1]
	end

	always_ff @(posedge clk) begin
		if (rst)
			loop_bypass_reg <= VPC_RST_LOOP_BYPASS; // [R2]
		else if (wr_loop_bypass)
			loop_bypass_reg <= req.wdata[VPC_BIT_LOOP_BYPASS]; // [R2]
	end

	always_ff @(posedge clk) begin
		if (rst)
			tune_pol_reg <= VPC_RST_TUNE_POL; // [R3]
		else if (wr_tune_pump)
			tune_pol_reg <= req.wdata[VPC_BIT_TUNE_POL]; // [R3]
	end

	// Resets high so the oscillator starts centred; the host clears it to lock
	always_ff @(posedge clk) begin
		if (rst)
			force_mid_reg <= VPC_RST_FORCE_MID; // [R4]
		else if (wr_tune_pump)
			force_mid_reg <= req.wdata[VPC_BIT_FORCE_MID]; // [R4] [R5]
	end

	always_ff @(posedge clk) begin
		if (rst)
			pump_reg <= VPC_RST_PUMP; // [R7]
		else if (wr_tune_pump)
			pump_reg <= req.wdata[VPC_PUMP_LSB +: VPC_PUMP_W]; // [R6]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_pwr_reg <= VPC_RST_OSC_PWR; // [R8]
			osc_out_rest_reg <= VPC_RST_OSC_REST;
		end else if (wr_osc_out) begin
			osc_pwr_reg <= req.wdata[VPC_BIT_OSC_PWR]; // [R8]
			osc_out_rest_reg <= req.wdata[6:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			loop2_reg <= VPC_RST_LOOP2;
		else if (wr_loop2_pump)
			loop2_reg <= req.wdata[6:0]; // Bit 7 reserved [R9]
	end

	always_comb begin
		img_fb_cascade = 8'h00;
		img_fb_cascade[VPC_BIT_FB_CASCADE] = fb_cascade_reg;
		img_loop_bypass = 8'h00;
		img_loop_bypass[VPC_BIT_LOOP_BYPASS] = loop_bypass_reg;
		img_tune_pump = 8'h00; // Bit 5 reserved [R9]
		img_tune_pump[VPC_BIT_TUNE_POL] = tune_pol_reg;
		img_tune_pump[VPC_BIT_FORCE_MID] = force_mid_reg;
		img_tune_pump[VPC_PUMP_LSB +: VPC_PUMP_W] = pump_reg;
		img_osc_out = {osc_pwr_reg, osc_out_rest_reg};
		img_loop2_pump = {1'h0, loop2_reg}; // Bit 7 reserved [R9]
	end

	// Unmapped addresses fall to the default and read zero [R9]
	always_comb begin
		case (req.addr)
			VPC_ADDR_FB_CASCADE: rd_next = img_fb_cascade;
			VPC_ADDR_LOOP_BYPASS: rd_next = img_loop_bypass;
			VPC_ADDR_TUNE_PUMP: rd_next = img_tune_pump;
			VPC_ADDR_OSC_OUT: rd_next = img_osc_out;
			VPC_ADDR_LOOP2_PUMP: rd_next = img_loop2_pump;
			default: rd_next = 8'h00;
		endcase
	end

	// Read data holds between reads so a slow host may sample it late
	always_ff @(posedge clk) begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (req.rd)
			rdata_reg <= rd_next;
	end

	always_ff @(posedge clk) begin
		if (rst)
			rvalid_reg <= 1'h0;
		else
			rvalid_reg <= req.rd;
	end

	vpc_pump_dac u_pump (
		.clk(clk),
		.rst(rst),
		.code(pump_reg),
		.current_ua(first_loop_pump_ua)
	);

	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;
	assign feedback_cascade_select = fb_cascade_reg;
	assign first_loop_bypass = loop_bypass_reg;
	assign tuning_polarity = tune_pol_reg;
	assign force_mid_tuning = force_mid_reg;
	assign osc_copy_output_power = osc_pwr_reg;
	// Struct and single-bit outputs share the same flops, so they cannot disagree
	always_comb begin
		ctrl.feedback_cascade_select = fb_cascade_reg;
		ctrl.first_loop_bypass = loop_bypass_reg;
		ctrl.tuning_polarity = tune_pol_reg;
		ctrl.force_mid_tuning = force_mid_reg;
		ctrl.first_loop_pump_current = pump_reg;
		ctrl.osc_copy_output_power = osc_pwr_reg;
	end
endmodule
`default_nettype wire

// >>> testbench/vpc_regs_monitor.sv
/* Port checker for vpc_regs.
 Assumes clk and synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module vpc_regs_monitor (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire vpc_pkg::vpc_req_t req, // Request
	input wire logic [7:0] rdata, // Read data
	input wire logic rvalid, // Read valid
	input wire vpc_pkg::vpc_ctrl_t ctrl, // Fields
	input wire logic feedback_cascade_select, // Cascade
	input wire logic first_loop_bypass, // Bypass
	input wire logic tuning_polarity, // Slope
	input wire logic force_mid_tuning, // Force mid
	input wire logic osc_copy_output_power, // Copy power
	input wire logic [10:0] first_loop_pump_ua // Pump
);
	import vpc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rd_answer_a: assert property (req.rd |=> rvalid) else $error("no rvalid");
	rd_quiet_a: assert property (!req.rd |=> !rvalid) else $error("stray rvalid");
	cascade_write_a: assert property (req.wr && req.addr == 8'h03 |=>
		feedback_cascade_select == $past(req.wdata[0])) else $error("cascade");
	bypass_write_a: assert property (req.wr && req.addr == 8'h0A |=>
		first_loop_bypass == $past(req.wdata[0])) else $error("bypass");
	tune_write_a: assert property (req.wr && req.addr == 8'h10 |=>
		{tuning_polarity, force_mid_tuning} == $past(req.wdata[7:6])) else $error("tune");
	osc_write_a: assert property (req.wr && req.addr == 8'h11 |=>
		osc_copy_output_power == $past(req.wdata[7])) else $error("osc");
	pump_current_a: assert property (!$past(rst) |-> first_loop_pump_ua ==
		11'(50 * ($past(ctrl.first_loop_pump_current) + 1))) else $error("pump");
	reset_fields_a: assert property ($fell(rst) |->
		force_mid_tuning && ctrl.first_loop_pump_current == 5'h18 && !tuning_polarity &&
		!first_loop_bypass && !feedback_cascade_select && !osc_copy_output_power &&
		rdata == 8'h00 && !rvalid)
		else $error("reset");
	reserved_zero_a: assert property (req.rd && (req.addr == 8'h03 || req.addr == 8'h0A)
		|=> rdata[7:1] == 7'h00) else $error("reserved");
	pump_write_a: assert property (req.wr && req.addr == 8'h10 |=>
		ctrl.first_loop_pump_current == $past(req.wdata[4:0])) else $error("pump write");
	tune_reserved_a: assert property (req.rd && req.addr == 8'h10 |=> !rdata[5])
		else $error("reserved tuning_and_pump_ctrl");
	loop2_reserved_a: assert property (req.rd && req.addr == 8'h12 |=> !rdata[7])
		else $error("reserved second_loop_pump_ctrl");
	unmapped_read_a: assert property (req.rd &&
		!(req.addr inside {8'h03, 8'h0A, 8'h10, 8'h11, 8'h12}) |=> rdata == 8'h00)
		else $error("unmapped read");
	old_on_write_a: assert property (req.rd && req.wr && req.addr == 8'h10 |=>
		rdata[7:6] == $past({tuning_polarity, force_mid_tuning})) else $error("read order");
endmodule
bind vpc_regs vpc_regs_monitor u_mon (.clk, .rst, .req, .rdata, .rvalid, .ctrl,
	.feedback_cascade_select, .first_loop_bypass, .tuning_polarity, .force_mid_tuning,
	.osc_copy_output_power, .first_loop_pump_ua);
`default_nettype wire

// >>> testbench/vpc_regs_bench.sv
/* Self-checking bench for vpc_regs against a shadow register copy.
 Assumes the monitor is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module vpc_regs_bench;
	import vpc_pkg::*;
	logic clk = 0, rst = 1, rvalid, fcs, flb, tp, fmt, ocp;
	vpc_req_t req = '0;
	vpc_ctrl_t ctrl;
	logic [7:0] rdata, d;
	logic [10:0] ua;
	logic [7:0] sh [5];
	logic [7:0] adr [6] = '{8'h03, 8'h0A, 8'h10, 8'h11, 8'h12, 8'h20};
	int n_fail = 0, compares = 0, cyc = 0, seed = 32'h3f7d, k, i, w;
	vpc_regs dut (.clk, .rst, .req, .rdata, .rvalid, .ctrl, .feedback_cascade_select(fcs),
		.first_loop_bypass(flb), .tuning_polarity(tp), .force_mid_tuning(fmt),
		.osc_copy_output_power(ocp), .first_loop_pump_ua(ua));
	initial forever #12.5 clk = ~clk;
	// Writable bits per index; index 5 is unmapped
	function automatic logic [7:0] msk(int j);
		return j < 2 ? 8'h01 : j == 2 ? 8'hDF : j == 3 ? 8'hFF : j == 4 ? 8'h7F : 8'h00;
	endfunction
	// Pump current is one 50 uA step per code, plus one step
	function automatic logic [10:0] exp_ua(logic [4:0] c);
		return 11'(50 * (c + 1));
	endfunction
	// Control struct image from the shadow copy, first field just below a zero top bit
	function automatic logic [10:0] exp_ctrl();
		return {1'b0, sh[0][0], sh[1][0], sh[2][7], sh[2][6], sh[2][4:0], sh[3][7]};
	endfunction
	task automatic chk(input logic [10:0] g, e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input int j, input logic [7:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: adr[j], wdata: v};
		@(posedge clk);
		req.wr <= 1'b0;
		if (j < 5) sh[j] = v & msk(j);
	endtask
	task automatic rd(input int j);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: adr[j], wdata: 8'h00};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rvalid, 1'b1);
		chk(rdata, j < 5 ? sh[j] : 8'h00);
	endtask
	// Write and read in one cycle: the read returns the value from before the write
	task automatic wrd(input int j, input logic [7:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b1, addr: adr[j], wdata: v};
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		#1 chk(rvalid, 1'b1);
		chk(rdata, sh[j]);
		sh[j] = v & msk(j);
	endtask
	task automatic outs();
		chk(fcs, sh[0][0]);
		chk(flb, sh[1][0]);
		chk(tp, sh[2][7]);
		chk(fmt, sh[2][6]);
		chk(ocp, sh[3][7]);
		chk(ua, exp_ua(sh[2][4:0]));
		chk(11'(ctrl), exp_ctrl());
	endtask
	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		for (k = 0; k < 2; k++) begin
			sh = '{8'h00, 8'h00, 8'h58, 8'h00, 8'h18};
			repeat (3 - 2 * k) @(posedge clk);
			rst <= 1'b0;
			for (i = 0; i < 6; i++) rd(i);
			outs();
			if (k == 0) wr(2, 8'h18);
			// Ones then zeros everywhere before the random mix
			for (i = 0; i < 72 && k == 0; i++) begin
				d = i < 6 ? 8'hFF : i < 12 ? 8'h00 : 8'($random(seed));
				w = i < 12 ? i % 6 : {$random(seed)} % 6;
				wr(w, d);
				rd(w);
				if (i % 8 == 7) wrd(i % 5, 8'($random(seed)));
				for (int j = 0; j < 6; j++) rd(j);
				outs();
			end
			@(posedge clk);
			rst <= 1'b1;
		end
		summarize();
	end
endmodule
`default_nettype wire
